// *** aap_defines.svh ***
`ifndef AAP_DEFINES_SVH
`define AAP_DEFINES_SVH

// Clock and timing
`define AAP_CLK_HZ 10000000
`define AAP_TICK_NS 1000000
`define AAP_TICK_CYC ((`AAP_TICK_NS / 1000) * (`AAP_CLK_HZ / 1000000))
`define AAP_GR_MS 13'd3000
`define AAP_TEST_MS 13'd5000
`define AAP_DEB_MS 5'd20
`define AAP_BLINK_MS 9'd500
`define AAP_RPM_SLOW 16'd800

// Register byte offsets
`define AAP_REG_CTRL 8'h00
`define AAP_REG_STAT 8'h04
`define AAP_REG_ALM 8'h08
`define AAP_REG_UNACK 8'h0c
`define AAP_REG_LATCH 8'h10
`define AAP_REG_IRQ_ST 8'h14
`define AAP_REG_IRQ_MASK 8'h18

// Control fields and reset values
`define AAP_CTRL_DIM_EN 0
`define AAP_CTRL_MIN_LO 8
`define AAP_CTRL_MIN_HI 15
`define AAP_CTRL_RST 32'h0000_2001
`define AAP_MASK_RST 5'h00

// Interrupt status bits
`define AAP_IRQ_NEW 0
`define AAP_IRQ_ACK 1
`define AAP_IRQ_RESET 2
`define AAP_IRQ_LINK 3
`define AAP_IRQ_INT 4

`endif

// *** aap_pkg.sv ***
package aap_pkg;
  typedef enum logic [1:0] {
    AAP_CMD_NONE = 2'b00,
    AAP_CMD_HORN = 2'b01,
    AAP_CMD_OPTIC = 2'b10,
    AAP_CMD_RESET = 2'b11
  } aap_cmd_e;

  typedef enum logic {
    AAP_GR_IDLE = 1'b0,
    AAP_GR_PULSE = 1'b1
  } aap_gr_e;

  typedef logic [15:0] aap_pts_t;
endpackage : aap_pkg

// *** aap_top.sv ***
// Contract
// - Buzzer switches on whenever a new engine alarm is reported.
// - Pre-alarm flashes only its measuring-point LED, no status LED.
// - Master alarm flashes point LED and lights the alarm status LED.
// - Shutdown or slowdown alarm lights engine-stop or engine-slowdown LED.
// - On alarm close horn relay, de-energise group alarm relay.
// - New alarm while another active re-energises group relay about 3 s.
// - Acoustic acknowledge silences buzzer and releases horn relay.
// - Optical acknowledge turns every flashing point LED steady.
// - Acknowledged steady LED of an unlatched point goes out once the fault clears.
// - Shutdown or slowdown alarms stay latched until reset is pressed.
// - Reset honoured for shutdown at standstill, slowdown below 800 rpm.
// - Acknowledge and reset are sent on the bus; received ones act alike.
// - Alarm LED brightness follows the ambient light sensor.
// - Holding acoustic acknowledge about 5 s starts the horn test.
// - Failure LED flashes when bus communication fails.
// - Failure LED lights steadily on an internal fault.
`timescale 1ns/10ps
`include "aap_defines.svh"

module aap_top #(
  parameter int TICK_CYC = `AAP_TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r_q,
  output logic wb_ack_q,
  output logic irq_q,
  // Serial bus decoder, same clock
  input wire logic [15:0] fault_pts,
  input wire logic [15:0] master_pts,
  input wire logic [15:0] sd_pts,
  input wire logic [15:0] sl_pts,
  input wire logic [15:0] rpm,
  input wire logic link_ok,
  input wire logic rx_valid,
  input wire logic [1:0] rx_cmd,
  output logic tx_valid_q,
  output logic [1:0] tx_cmd_q,
  // Self test
  input wire logic int_fault,
  // Panel pins
  input wire logic btn_horn_ack,
  input wire logic btn_optic_ack,
  input wire logic btn_reset,
  input wire logic [7:0] amb_light,
  // Indicators and relays
  output logic [15:0] pt_led_q,
  output logic led_alarm_q,
  output logic led_stop_q,
  output logic led_slow_q,
  output logic led_fail_q,
  output logic buzzer_q,
  output logic horn_rly_q,
  output logic gr_coil_q
);

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : byte_mask

  // Tick: 1 ms strobe
  logic [23:0] tick_cnt_q;
  wire tick = (tick_cnt_q == 24'(TICK_CYC - 1));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tick_cnt_q <= 24'h000000;
    else tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
  end

  // Buttons: sync then debounce on ticks
  wire [2:0] btn_raw = {btn_reset, btn_optic_ack, btn_horn_ack};
  logic [2:0] btn_m_q;
  logic [2:0] btn_s_q;
  logic [2:0] btn_db_q;
  logic [2:0] btn_old_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      btn_m_q <= 3'h0;
      btn_s_q <= 3'h0;
      btn_old_q <= 3'h0;
    end else begin
      btn_m_q <= btn_raw;
      btn_s_q <= btn_m_q;
      btn_old_q <= btn_db_q;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
      logic [4:0] cnt_q;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_q <= 5'h00;
          btn_db_q[gi] <= 1'b0;
        end else if (btn_s_q[gi] == btn_db_q[gi]) begin
          cnt_q <= 5'h00;
        end else if (tick) begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `AAP_DEB_MS - 5'h01) btn_db_q[gi] <= btn_s_q[gi];
        end
      end
    end
  endgenerate
  wire [2:0] btn_ev = btn_db_q & ~btn_old_q;

  // remote commands act as local presses
  wire rx_horn = rx_valid && (rx_cmd == aap_pkg::AAP_CMD_HORN);
  wire rx_opt = rx_valid && (rx_cmd == aap_pkg::AAP_CMD_OPTIC);
  wire rx_rst = rx_valid && (rx_cmd == aap_pkg::AAP_CMD_RESET);
  wire do_hack = btn_ev[0] | rx_horn;
  wire do_oack = btn_ev[1] | rx_opt;
  wire do_rst = btn_ev[2] | rx_rst;

  // Alarm bookkeeping
  logic [15:0] fault_old_q;
  aap_pkg::aap_pts_t alm_q;
  aap_pkg::aap_pts_t unack_q;
  aap_pkg::aap_pts_t latch_q;
  wire [15:0] new_vec = fault_pts & ~fault_old_q;
  wire new_alm = |new_vec;
  wire busy_prev = |(alm_q & ~new_vec);
  wire rpm_zero = (rpm == 16'h0000);
  wire rpm_low = (rpm < `AAP_RPM_SLOW);
  wire [15:0] rst_clr = {16{do_rst}} & ((sd_pts & {16{rpm_zero}}) | (sl_pts & ~sd_pts & {16{rpm_low}}));
  wire [15:0] unack_d = new_vec | (unack_q & ~{16{do_oack}});
  // latch until honoured reset, set wins
  wire [15:0] latch_d = (new_vec & (sd_pts | sl_pts)) | (latch_q & ~rst_clr);
  // lit while faulty, unacknowledged or latched
  wire [15:0] alm_d = new_vec | (alm_q & (fault_pts | unack_q | latch_q));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_old_q <= 16'h0000;
      alm_q <= 16'h0000;
      unack_q <= 16'h0000;
      latch_q <= 16'h0000;
    end else begin
      fault_old_q <= fault_pts;
      alm_q <= alm_d;
      unack_q <= unack_d;
      latch_q <= latch_d;
    end
  end

  // Blink and dimming
  logic [8:0] blink_ms_q;
  logic blink_q;
  logic [7:0] pwm_q;
  logic [7:0] amb_m_q;
  logic [7:0] amb_s_q;
  logic [31:0] ctrl_q;
  wire [7:0] min_duty = ctrl_q[`AAP_CTRL_MIN_HI:`AAP_CTRL_MIN_LO];
  wire [7:0] duty = (amb_s_q > min_duty) ? amb_s_q : min_duty;
  wire pwm_on = !ctrl_q[`AAP_CTRL_DIM_EN] || (duty == 8'hff) || (pwm_q < duty);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      blink_ms_q <= 9'h000;
      blink_q <= 1'b0;
      pwm_q <= 8'h00;
      amb_m_q <= 8'h00;
      amb_s_q <= 8'h00;
    end else begin
      pwm_q <= pwm_q + 8'h01;
      amb_m_q <= amb_light;
      amb_s_q <= amb_m_q;
      if (tick) begin
        blink_ms_q <= (blink_ms_q == `AAP_BLINK_MS - 9'h001) ? 9'h000 : blink_ms_q + 9'h001;
        if (blink_ms_q == `AAP_BLINK_MS - 9'h001) blink_q <= ~blink_q;
      end
    end
  end

  // Horn, buzzer and horn test
  logic horn_q;
  logic [12:0] hold_ms_q;
  wire hold_full = (hold_ms_q == `AAP_TEST_MS);
  // new alarm sounds horn; acoustic ack silences it
  wire horn_d = new_alm | (horn_q & ~do_hack);
  wire test_d = hold_full & btn_db_q[0];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      horn_q <= 1'b0;
      hold_ms_q <= 13'h0000;
    end else begin
      horn_q <= horn_d;
      if (!btn_db_q[0]) hold_ms_q <= 13'h0000;
      else if (tick && !hold_full) hold_ms_q <= hold_ms_q + 13'h0001;
    end
  end

  // Group alarm relay repeat pulse
  aap_pkg::aap_gr_e gr_st_q;
  aap_pkg::aap_gr_e gr_st_d;
  logic [12:0] gr_ms_q;
  wire gr_start = new_alm & busy_prev;
  wire gr_done = tick && (gr_ms_q == `AAP_GR_MS - 13'h0001);
  // repeat pulse for a new alarm over an active one
  always_comb begin
    gr_st_d = gr_st_q;
    case (gr_st_q)
      aap_pkg::AAP_GR_IDLE: begin
        if (gr_start) gr_st_d = aap_pkg::AAP_GR_PULSE;
      end
      aap_pkg::AAP_GR_PULSE: begin
        if (gr_done && !gr_start) gr_st_d = aap_pkg::AAP_GR_IDLE;
      end
      default: gr_st_d = aap_pkg::AAP_GR_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gr_st_q <= aap_pkg::AAP_GR_IDLE;
      gr_ms_q <= 13'h0000;
    end else begin
      gr_st_q <= gr_st_d;
      if (gr_start || gr_st_q == aap_pkg::AAP_GR_IDLE) gr_ms_q <= 13'h0000;
      else if (tick) gr_ms_q <= gr_ms_q + 13'h0001;
    end
  end

  // Indicator outputs
  wire [15:0] pt_led_d = alm_q & (~unack_q | {16{blink_q}}) & {16{pwm_on}};
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pt_led_q <= 16'h0000;
      led_alarm_q <= 1'b0;
      led_stop_q <= 1'b0;
      led_slow_q <= 1'b0;
      led_fail_q <= 1'b0;
      buzzer_q <= 1'b0;
      horn_rly_q <= 1'b0;
      gr_coil_q <= 1'b1;
    end else begin
      // point LED flashes until optical ack
      pt_led_q <= pt_led_d;
      led_alarm_q <= |(alm_q & master_pts) & pwm_on;
      led_stop_q <= |(alm_q & sd_pts) & pwm_on;
      led_slow_q <= |(alm_q & sl_pts) & pwm_on;
      led_fail_q <= int_fault | (~link_ok & blink_q);
      buzzer_q <= horn_d | test_d;
      horn_rly_q <= horn_d | test_d;
      // group relay drops on alarm, pulse lifts it
      gr_coil_q <= ~(|alm_d) | (gr_st_d == aap_pkg::AAP_GR_PULSE);
    end
  end

  // Bus transmit, one command per cycle from pending set
  logic [2:0] tx_pend_q;
  wire [2:0] pend_all = tx_pend_q | btn_ev;
  wire [2:0] tx_pick = pend_all & ~(pend_all - 3'h1);
  wire [2:0] tx_pend_d = pend_all & ~tx_pick;
  wire [1:0] tx_code = tx_pick[0] ? aap_pkg::AAP_CMD_HORN :
                       tx_pick[1] ? aap_pkg::AAP_CMD_OPTIC : aap_pkg::AAP_CMD_RESET;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_pend_q <= 3'h0;
      tx_valid_q <= 1'b0;
      tx_cmd_q <= 2'h0;
    end else begin
      // local presses go out on the bus
      tx_pend_q <= tx_pend_d;
      tx_valid_q <= |pend_all;
      tx_cmd_q <= (|pend_all) ? tx_code : aap_pkg::AAP_CMD_NONE;
    end
  end

  // Interrupt status, set wins over clear
  logic [4:0] ist_q;
  logic [4:0] imask_q;
  logic link_old_q;
  logic intf_old_q;
  wire wb_req = wb_cyc & wb_stb & ~wb_ack_q;
  wire wb_wr = wb_req & wb_we;
  wire [31:0] wmask = wb_dat_w & byte_mask(wb_sel);
  wire sel_ctrl = (wb_adr == `AAP_REG_CTRL);
  wire sel_stat = (wb_adr == `AAP_REG_STAT);
  wire sel_alm = (wb_adr == `AAP_REG_ALM);
  wire sel_unack = (wb_adr == `AAP_REG_UNACK);
  wire sel_latch = (wb_adr == `AAP_REG_LATCH);
  wire sel_ist = (wb_adr == `AAP_REG_IRQ_ST);
  wire sel_imask = (wb_adr == `AAP_REG_IRQ_MASK);
  wire [4:0] ev_vec = {int_fault & ~intf_old_q, link_old_q & ~link_ok, do_rst, do_hack | do_oack, new_alm};
  wire [4:0] w1c = (wb_wr && sel_ist) ? wmask[4:0] : 5'h00;
  wire [4:0] ist_d = ev_vec | (ist_q & ~w1c);
  wire [31:0] ctrl_d = (wb_wr && sel_ctrl) ? ((ctrl_q & ~byte_mask(wb_sel)) | wmask) : ctrl_q;
  wire [4:0] imask_d = (wb_wr && sel_imask && wb_sel[0]) ? wb_dat_w[4:0] : imask_q;
  wire [31:0] stat_w = {25'h0, gr_st_q == aap_pkg::AAP_GR_PULSE, test_d, ~link_ok, int_fault,
                        gr_coil_q, horn_q, |alm_q};
  wire [31:0] rd_d = sel_ctrl ? ctrl_q :
                     sel_stat ? stat_w :
                     sel_alm ? {16'h0000, alm_q} :
                     sel_unack ? {16'h0000, unack_q} :
                     sel_latch ? {16'h0000, latch_q} :
                     sel_ist ? {27'h0, ist_q} :
                     sel_imask ? {27'h0, imask_q} : 32'h0000_0000;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `AAP_CTRL_RST;
      ist_q <= 5'h00;
      imask_q <= `AAP_MASK_RST;
      link_old_q <= 1'b1;
      intf_old_q <= 1'b0;
      wb_ack_q <= 1'b0;
      wb_dat_r_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      link_old_q <= link_ok;
      intf_old_q <= int_fault;
      wb_ack_q <= wb_req;
      wb_dat_r_q <= (wb_req && !wb_we) ? rd_d : 32'h0000_0000;
      irq_q <= |(ist_d & imask_d);
    end
  end

  // Checks
  sequence s_new_busy;
    new_alm && busy_prev;
  endsequence
  sequence s_hold_done;
    btn_db_q[0] && hold_full;
  endsequence

  chk_buzz_on: assert property (@(posedge sys_clk) disable iff (!rstn)
    new_alm |=> buzzer_q && horn_rly_q) else $error("buzzer not on after new alarm");
  chk_horn_ack: assert property (@(posedge sys_clk) disable iff (!rstn)
    do_hack && !new_alm && !test_d |=> !horn_rly_q) else $error("horn not released on ack");
  chk_gr_repeat: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_new_busy |=> gr_coil_q [*2]) else $error("group repeat pulse missing");
  chk_gr_length: assert property (@(posedge sys_clk) disable iff (!rstn)
    gr_st_q == aap_pkg::AAP_GR_PULSE |-> gr_ms_q < `AAP_GR_MS) else $error("group pulse too long");
  chk_gr_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    (|(alm_q & fault_pts)) && gr_st_q == aap_pkg::AAP_GR_IDLE && !gr_start |=> !gr_coil_q)
    else $error("group relay not dropped");
  chk_optic_ack: assert property (@(posedge sys_clk) disable iff (!rstn)
    do_oack && !new_alm |=> unack_q == 16'h0000) else $error("flashing remains after optic ack");
  chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !do_rst |=> ($past(latch_q) & ~latch_q) == 16'h0000) else $error("latch lost without reset");
  chk_rst_speed: assert property (@(posedge sys_clk) disable iff (!rstn)
    do_rst && !rpm_low |=> (($past(latch_q) & ~latch_q) == 16'h0000))
    else $error("reset honoured at speed");
  chk_test_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_hold_done |=> buzzer_q && horn_rly_q) else $error("horn test did not start");
  chk_fail_int: assert property (@(posedge sys_clk) disable iff (!rstn)
    int_fault |=> led_fail_q) else $error("failure LED not steady");
  chk_fail_link: assert property (@(posedge sys_clk) disable iff (!rstn)
    !link_ok && !int_fault && !blink_q |=> !led_fail_q) else $error("failure LED not flashing");
  chk_tx_send: assert property (@(posedge sys_clk) disable iff (!rstn)
    |btn_ev |=> tx_valid_q) else $error("press not sent on bus");
  chk_pre_only: assert property (@(posedge sys_clk) disable iff (!rstn)
    (alm_q & (master_pts | sd_pts | sl_pts)) == 16'h0000 && $stable(alm_q) |=> !led_alarm_q && !led_stop_q)
    else $error("status LED on for pre-alarm");

endmodule : aap_top

// *** aap_central_model.sv ***
`timescale 1ns/10ps

module aap_central_model (
  // Clock
  input wire logic sys_clk,
  // Decoded bus data toward the panel
  output logic [15:0] fault_pts = 16'h0000,
  output logic [15:0] master_pts = 16'h0000,
  output logic [15:0] sd_pts = 16'h0000,
  output logic [15:0] sl_pts = 16'h0000,
  output logic [15:0] rpm = 16'h0000,
  output logic link_ok = 1'b1,
  output logic rx_valid = 1'b0,
  output logic [1:0] rx_cmd = 2'h0,
  // Commands sent by the panel
  input wire logic tx_valid_q,
  input wire logic [1:0] tx_cmd_q
);
  logic [1:0] last_tx = 2'h0;

  always @(posedge sys_clk) begin
    if (tx_valid_q === 1'b1) last_tx <= tx_cmd_q;
  end

  // Type bits set with the fault; callers keep them static per point
  task setpt(input int p, input logic f, input logic m, input logic s, input logic l);
    @(posedge sys_clk);
    fault_pts[p] <= f;
    master_pts[p] <= m;
    sd_pts[p] <= s;
    sl_pts[p] <= l;
  endtask : setpt

  task ctl(input logic [15:0] r, input logic ok);
    @(posedge sys_clk);
    rpm <= r;
    link_ok <= ok;
  endtask : ctl

  task send(input logic [1:0] c);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_cmd <= c;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_cmd <= ~c;
  endtask : send
endmodule : aap_central_model

// *** alarm_annunciator_panel_bench.sv ***
`timescale 1ns/10ps
`include "aap_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module alarm_annunciator_panel_bench;
  localparam int TICK = 4;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r_q, rd_q;
  logic wb_ack_q, irq_q, tx_valid_q, link_ok, rx_valid;
  logic [1:0] tx_cmd_q, rx_cmd;
  logic [15:0] fault_pts, master_pts, sd_pts, sl_pts, rpm, pt_led_q;
  logic int_fault = 1'b0, btn_horn_ack = 1'b0, btn_optic_ack = 1'b0, btn_reset = 1'b0;
  logic [7:0] amb_light = 8'hff;
  logic led_alarm_q, led_stop_q, led_slow_q, led_fail_q, buzzer_q, horn_rly_q, gr_coil_q;
  logic [1:0] psel = 2'h0;
  int mismatches = 0;
  int n_compared = 0;
  int ticks = 0;
  wire probe = psel == 2'h0 ? pt_led_q[0] : psel == 2'h1 ? led_fail_q : led_alarm_q;

  always #50 sys_clk = ~sys_clk;

  aap_top #(.TICK_CYC(TICK)) u_aap_top (.sys_clk, .rstn, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
    .wb_dat_w, .wb_dat_r_q, .wb_ack_q, .irq_q, .fault_pts, .master_pts, .sd_pts, .sl_pts, .rpm,
    .link_ok, .rx_valid, .rx_cmd, .tx_valid_q, .tx_cmd_q, .int_fault, .btn_horn_ack, .btn_optic_ack,
    .btn_reset, .amb_light, .pt_led_q, .led_alarm_q, .led_stop_q, .led_slow_q, .led_fail_q,
    .buzzer_q, .horn_rly_q, .gr_coil_q);

  aap_central_model u_aap_central_model (.sys_clk, .fault_pts, .master_pts, .sd_pts, .sl_pts,
    .rpm, .link_ok, .rx_valid, .rx_cmd, .tx_valid_q, .tx_cmd_q);

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  always @(posedge sys_clk) begin
    ticks++;
    if (ticks == 60000) begin
      mismatches++;
      test_done;
    end
  end

  // Ack and read data taken at the rising edge; design outputs move by NBA
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    do @(posedge sys_clk); while (wb_ack_q !== 1'b1);
    rd_q = wb_dat_r_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, rd_q)
  endtask : rdc

  task obs(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : obs

  task sample(input int n, output int hi, output int tg);
    logic last;
    hi = 0;
    tg = 0;
    @(negedge sys_clk);
    last = probe;
    repeat (n) begin
      @(negedge sys_clk);
      hi += probe;
      tg += (probe != last);
      last = probe;
    end
  endtask : sample

  initial begin
    int hi, tg;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    obs(1);
    `CHK("gr_coil rst", 1'b1, gr_coil_q)
    rdc(`AAP_REG_CTRL, 32'h0000_2001, "ctrl");
    rdc(`AAP_REG_IRQ_MASK, 32'h0, "mask");
    rdc(8'h40, 32'h0, "unmapped");
    wb(1'b1, `AAP_REG_CTRL, 32'h0);
    u_aap_central_model.setpt(0, 1'b1, 1'b0, 1'b0, 1'b0);
    obs(3);
    `CHK("buzzer", 1'b1, buzzer_q)
    `CHK("horn", 1'b1, horn_rly_q)
    `CHK("gr_coil", 1'b0, gr_coil_q)
    `CHK("led_alarm", 1'b0, led_alarm_q)
    sample(2100, hi, tg);
    `CHK("pt0 flash", 1'b1, tg > 0)
    u_aap_central_model.setpt(1, 1'b1, 1'b1, 1'b0, 1'b0);
    obs(3);
    `CHK("led_alarm", 1'b1, led_alarm_q)
    `CHK("gr pulse", 1'b1, gr_coil_q)
    obs(3000 * TICK - 150);
    `CHK("gr pulse", 1'b1, gr_coil_q)
    obs(300);
    `CHK("gr end", 1'b0, gr_coil_q)
    @(posedge sys_clk) btn_horn_ack <= 1'b1;
    obs(120);
    `CHK("buzzer", 1'b0, buzzer_q)
    `CHK("horn", 1'b0, horn_rly_q)
    `CHK("tx", aap_pkg::AAP_CMD_HORN, u_aap_central_model.last_tx)
    @(posedge sys_clk) btn_horn_ack <= 1'b0;
    @(posedge sys_clk) btn_optic_ack <= 1'b1;
    obs(120);
    rdc(`AAP_REG_UNACK, 32'h0, "unack");
    `CHK("tx", aap_pkg::AAP_CMD_OPTIC, u_aap_central_model.last_tx)
    @(posedge sys_clk) btn_optic_ack <= 1'b0;
    sample(2100, hi, tg);
    `CHK("pt0 steady", 2100, hi)
    u_aap_central_model.setpt(0, 1'b0, 1'b0, 1'b0, 1'b0);
    obs(3);
    `CHK("pt0 off", 1'b0, pt_led_q[0])
    rdc(`AAP_REG_ALM, 32'h2, "alm");
    u_aap_central_model.ctl(16'd1000, 1'b1);
    u_aap_central_model.setpt(2, 1'b1, 1'b1, 1'b1, 1'b0);
    u_aap_central_model.setpt(3, 1'b1, 1'b1, 1'b0, 1'b1);
    obs(3);
    `CHK("led_stop", 1'b1, led_stop_q)
    `CHK("led_slow", 1'b1, led_slow_q)
    u_aap_central_model.send(aap_pkg::AAP_CMD_OPTIC);
    u_aap_central_model.setpt(2, 1'b0, 1'b1, 1'b1, 1'b0);
    u_aap_central_model.setpt(3, 1'b0, 1'b1, 1'b0, 1'b1);
    obs(3);
    rdc(`AAP_REG_LATCH, 32'hc, "latch");
    `CHK("led_stop", 1'b1, led_stop_q)
    @(posedge sys_clk) btn_reset <= 1'b1;
    obs(120);
    `CHK("tx", aap_pkg::AAP_CMD_RESET, u_aap_central_model.last_tx)
    rdc(`AAP_REG_LATCH, 32'hc, "latch");
    @(posedge sys_clk) btn_reset <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_aap_central_model.ctl(i == 0 ? 16'd800 : i == 1 ? 16'd799 : 16'd0, 1'b1);
      u_aap_central_model.send(aap_pkg::AAP_CMD_RESET);
      obs(3);
      rdc(`AAP_REG_LATCH, i == 0 ? 32'hc : i == 1 ? 32'h4 : 32'h0, "latch");
    end
    `CHK("led_stop", 1'b0, led_stop_q)
    u_aap_central_model.send(aap_pkg::AAP_CMD_HORN);
    obs(3);
    `CHK("buzzer", 1'b0, buzzer_q)
    @(posedge sys_clk) btn_horn_ack <= 1'b1;
    obs(19900);
    `CHK("test early", 1'b0, buzzer_q)
    obs(400);
    `CHK("test buzzer", 1'b1, buzzer_q)
    `CHK("test horn", 1'b1, horn_rly_q)
    @(posedge sys_clk) btn_horn_ack <= 1'b0;
    obs(120);
    `CHK("test end", 1'b0, buzzer_q)
    u_aap_central_model.ctl(16'd0, 1'b0);
    psel = 2'h1;
    sample(2100, hi, tg);
    `CHK("fail flash", 1'b1, tg > 0)
    u_aap_central_model.ctl(16'd0, 1'b1);
    @(posedge sys_clk) int_fault <= 1'b1;
    obs(3);
    sample(2100, hi, tg);
    `CHK("fail steady", 2100, hi)
    wb(1'b1, `AAP_REG_CTRL, 32'h0000_2001);
    psel = 2'h2;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) amb_light <= i ? 8'h80 : 8'h10;
      obs(10);
      sample(1024, hi, tg);
      `CHK("dim duty", 1'b1, hi >= (i ? 504 : 120) && hi <= (i ? 520 : 136))
    end
    rdc(`AAP_REG_IRQ_ST, 32'h1f, "irq_st");
    `CHK("irq masked", 1'b0, irq_q)
    wb(1'b1, `AAP_REG_IRQ_MASK, 32'h1);
    obs(2);
    `CHK("irq", 1'b1, irq_q)
    wb(1'b1, `AAP_REG_IRQ_ST, 32'h1f);
    obs(2);
    `CHK("irq clr", 1'b0, irq_q)
    rdc(`AAP_REG_IRQ_ST, 32'h0, "irq_st");
    test_done;
  end
endmodule : alarm_annunciator_panel_bench
